// ---- logic/omlc_output_mute_level_control.sv ----
// Notes on behaviour
// - Four 2-bit RW fields, drivers 7..4.
// - Diff: 0 bypass, 1 Vcm, 2 high.
// - Diff code 3: P to rail, N ground.
// - CMOS: per-code low forcing of P/N.
// - Field selects state, not mute entry.
// - Mute when enabled and source invalid.
//
// Our own choice: register access over APB.

`timescale 1ns/1ps
`include "omlc_defs.svh"

module omlc_output_mute_level_control
	import omlc_pkg::*;
(
	input  wire logic        pclk,            // Register clock, 250 MHz
	input  wire logic        presetn,         // Async reset, active low
	input  wire logic        psel,            // APB select
	input  wire logic        penable,         // APB access phase
	input  wire logic        pwrite,          // APB direction
	input  wire logic [7:0]  paddr,           // APB byte address
	input  wire logic [31:0] pwdata,          // APB write data
	output logic      [31:0] prdata,          // APB read data
	output logic             pready,          // APB ready
	output logic             pslverr,         // APB error, unmapped address
	input  wire logic        source_invalid,  // Selected clock source invalid (pin)
	output logic      [3:0]  driver_muted,    // Driver 7..4 is in mute
	output logic      [7:0]  diff_action,     // Diff action per driver, 2 bits each
	output logic      [3:0]  cmos_force_p_low,// CMOS P forced low
	output logic      [3:0]  cmos_force_n_low // CMOS N forced low
);

	// ----------------------------------------
	// Storage
	// ----------------------------------------
	logic [7:0] upper_driver_mute_levels_reg;      // Mute level fields
	logic [3:0] channel_auto_silence_enable_reg;   // Per-driver enables
	logic [3:0] cmos_mode_reg;                     // 1 = driver in CMOS mode
	logic [2:0] invalid_sync_reg;                  // Pin synchroniser
	logic       invalid_reg;                       // Filtered source state
	logic       access;                            // Completing APB access
	logic       wr;                                // Write strobe
	logic       hit;                               // Mapped address

	// Next values, worked out combinationally and then registered
	// so that every output of the block leaves from a flip-flop
	logic [31:0] read_data_next;                   // Word for the coming access cycle
	logic        slave_error_next;                 // Error for the coming access cycle
	logic [3:0]  driver_muted_next;                // Mute entry per driver
	logic [7:0]  diff_action_next;                 // Diff action per driver
	logic [3:0]  force_p_low_next;                 // CMOS P low per driver
	logic [3:0]  force_n_low_next;                 // CMOS N low per driver

	assign access = psel & penable;
	assign wr     = access & pwrite;
	assign hit    = (paddr == `OMLC_LEVELS_ADDR) | (paddr == `OMLC_SILENCE_ADDR)
		| (paddr == `OMLC_STATUS_ADDR);

	// ----------------------------------------
	// Register writes
	// ----------------------------------------
	// Any code is accepted; 3 is only advised for software
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			upper_driver_mute_levels_reg <= `OMLC_LEVELS_RESET;
		else if (wr && paddr == `OMLC_LEVELS_ADDR)
			upper_driver_mute_levels_reg <= pwdata[7:0];
	end

	// Enables and mode bits share one word of our own
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			channel_auto_silence_enable_reg <= `OMLC_SILENCE_RESET;
			cmos_mode_reg                   <= `OMLC_MODE_RESET;
		end
		else if (wr && paddr == `OMLC_SILENCE_ADDR)
		begin
			channel_auto_silence_enable_reg <= pwdata[3:0];
			cmos_mode_reg                   <= pwdata[7:4];
		end
	end

	// ----------------------------------------
	// APB answer: always one access cycle, zero wait
	// ----------------------------------------
	// Read word chosen in the setup cycle, shown in the access cycle
	always_comb
	begin
		read_data_next   = 32'h0000_0000;
		slave_error_next = 1'b0;
		if (psel && !penable)
		begin
			// Unmapped offsets answer with an error, reads give zero
			slave_error_next = ~hit;
			if (!pwrite)
			begin
				// Status is taken at the setup edge, so it is one cycle old
				if (paddr == `OMLC_LEVELS_ADDR)
					read_data_next = {24'h00_0000, upper_driver_mute_levels_reg};
				else if (paddr == `OMLC_SILENCE_ADDR)
					read_data_next = {24'h00_0000, cmos_mode_reg,
						channel_auto_silence_enable_reg};
				else if (paddr == `OMLC_STATUS_ADDR)
					read_data_next = {27'h000_0000, invalid_reg, driver_muted};
			end
		end
	end

	// Answer registers; ready is a one-cycle pulse in the access phase
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end
		else
		begin
			// Ready rises in the access phase, drops right after
			pready  <= psel & ~penable;
			pslverr <= slave_error_next;
			prdata  <= read_data_next;
		end
	end

	// ----------------------------------------
	// Source-invalid pin filter
	// ----------------------------------------
	// Change accepted only once stages two and three agree
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			invalid_sync_reg <= 3'h0;
			invalid_reg      <= 1'b0;
		end
		else
		begin
			invalid_sync_reg <= {invalid_sync_reg[1:0], source_invalid};
			if (invalid_sync_reg[1] == invalid_sync_reg[2])
				invalid_reg <= invalid_sync_reg[2];
		end
	end

	// ----------------------------------------
	// Driver control decode, one driver per pass
	// ----------------------------------------
	// Every code is legal, so the decode has no default branch.
	// Mode bits switch a driver between the two tables at once;
	// software should mute-free a driver before changing its mode.
	always_comb
	begin
		driver_muted_next = 4'h0;
		diff_action_next  = 8'h00;
		force_p_low_next  = 4'h0;
		force_n_low_next  = 4'h0;
		// Unmuted drivers keep every control at zero
		for (int i = 0; i < 4; i++)
		begin
			// Entry decided only by enable and source, never by field
			driver_muted_next[i] = channel_auto_silence_enable_reg[i] & invalid_reg;
			if (driver_muted_next[i] && !cmos_mode_reg[i])
			begin
				// Differential: each code names its own driver action
				unique case (omlc_level_type'(upper_driver_mute_levels_reg[2*i +: 2]))
					OMLC_BYPASS:     diff_action_next[2*i +: 2] = OMLC_DIFF_RUN;
					OMLC_LEVEL_LO:   diff_action_next[2*i +: 2] = OMLC_DIFF_VCM;
					OMLC_LEVEL_HI:   diff_action_next[2*i +: 2] = OMLC_DIFF_HIGH;
					OMLC_LEVEL_BOTH: diff_action_next[2*i +: 2] = OMLC_DIFF_RAILS;
				endcase
			end
			else if (driver_muted_next[i])
			begin
				// CMOS: forcing one half low leaves the other half running
				unique case (omlc_level_type'(upper_driver_mute_levels_reg[2*i +: 2]))
					OMLC_BYPASS:
					begin
						// Both halves keep running
						force_p_low_next[i] = 1'b0;
						force_n_low_next[i] = 1'b0;
					end
					OMLC_LEVEL_LO:
					begin
						// P keeps toggling, N held low
						force_p_low_next[i] = 1'b0;
						force_n_low_next[i] = 1'b1;
					end
					OMLC_LEVEL_HI:
					begin
						// P held low, N keeps toggling
						force_p_low_next[i] = 1'b1;
						force_n_low_next[i] = 1'b0;
					end
					OMLC_LEVEL_BOTH:
					begin
						// Both halves held low
						force_p_low_next[i] = 1'b1;
						force_n_low_next[i] = 1'b1;
					end
				endcase
			end
		end
	end

	// Driver controls leave through flip-flops, one cycle after decode
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			driver_muted     <= 4'h0;
			diff_action      <= 8'h00;
			cmos_force_p_low <= 4'h0;
			cmos_force_n_low <= 4'h0;
		end
		else
		begin
			driver_muted     <= driver_muted_next;
			diff_action      <= diff_action_next;
			cmos_force_p_low <= force_p_low_next;
			cmos_force_n_low <= force_n_low_next;
		end
	end

endmodule

// ---- logic/omlc_defs.svh ----
`ifndef OMLC_DEFS_SVH
`define OMLC_DEFS_SVH

// ----------------------------------------
// Register map (printed offsets are indices, byte address is four times)
// ----------------------------------------
`define OMLC_LEVELS_IDX      8'h15
`define OMLC_LEVELS_ADDR     8'h54
`define OMLC_SILENCE_ADDR    8'h58
`define OMLC_STATUS_ADDR     8'h5C

// ----------------------------------------
// Field layout and reset values
// ----------------------------------------
`define OMLC_FIELD_W         2
`define OMLC_LEVELS_RESET    8'h55
`define OMLC_SILENCE_RESET   4'hF
`define OMLC_MODE_RESET      4'h0

`endif

// ---- logic/omlc_pkg.sv ----
package omlc_pkg;

	// Muted-state code held in each 2-bit field
	typedef enum logic [1:0]
	{
		OMLC_BYPASS    = 2'b00,
		OMLC_LEVEL_LO  = 2'b01,
		OMLC_LEVEL_HI  = 2'b10,
		OMLC_LEVEL_BOTH= 2'b11
	} omlc_level_type;

	// Differential driver action while muted
	typedef enum logic [1:0]
	{
		OMLC_DIFF_RUN   = 2'b00,
		OMLC_DIFF_VCM   = 2'b01,
		OMLC_DIFF_HIGH  = 2'b10,
		OMLC_DIFF_RAILS = 2'b11
	} omlc_diff_type;

endpackage

// ---- tb/omlc_checker.sv ----
`timescale 1ns/1ps
`include "omlc_defs.svh"
// ----
// Port checks
// ----
module omlc_checker
(
	input wire logic        pclk,             // Clock
	input wire logic        presetn,          // Reset
	input wire logic        psel,             // Select
	input wire logic        penable,          // Access
	input wire logic        pwrite,           // Write
	input wire logic [7:0]  paddr,            // Address
	input wire logic [31:0] prdata,           // Read data
	input wire logic        pready,           // Ready
	input wire logic        pslverr,          // Error
	input wire logic        source_invalid,   // Source bad
	input wire logic [3:0]  driver_muted,     // Muted
	input wire logic [7:0]  diff_action,      // Diff
	input wire logic [3:0]  cmos_force_p_low, // P low
	input wire logic [3:0]  cmos_force_n_low  // N low
);
	logic       mapped; // Address decodes to a register
	logic [3:0] forced; // Any CMOS half forced low
	assign mapped = paddr inside {`OMLC_LEVELS_ADDR, `OMLC_SILENCE_ADDR, `OMLC_STATUS_ADDR};
	assign forced = cmos_force_p_low | cmos_force_n_low;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	chk_ready_now: assert property (psel && penable |-> pready)
		else $error("late ready");
	chk_ready_drop: assert property (pready |=> !pready)
		else $error("long ready");
	chk_upper_zero: assert property (pready && !pwrite |-> prdata[31:8] == '0)
		else $error("upper");
	chk_bad_addr: assert property (pready && !mapped |-> pslverr)
		else $error("no error");
	chk_good_addr: assert property (pready && mapped |-> !pslverr)
		else $error("false error");
	chk_cmos_gate: assert property ((forced & ~driver_muted) == 4'h0)
		else $error("cmos unmuted");
	chk_diff_own: assert property
		(diff_action[1:0] != 2'h0 |-> driver_muted[0] && !forced[0]) else $error("diff state");
	// Source good long enough means no driver may stay muted
	chk_quiet_src: assert property (!source_invalid [*6] |-> driver_muted == 4'h0)
		else $error("stuck mute");
	cover property (pready && pslverr);
	cover property (driver_muted == 4'hF);
	cover property (cmos_force_p_low != 4'h0);
	cover property (pready && !pwrite && paddr == `OMLC_STATUS_ADDR);
endmodule
bind omlc_output_mute_level_control omlc_checker chk_u (.pclk, .presetn, .psel, .penable,
	.pwrite, .paddr, .prdata, .pready, .pslverr, .source_invalid, .driver_muted, .diff_action,
	.cmos_force_p_low, .cmos_force_n_low);

// ---- tb/tb_output_mute_level_control.sv ----
`timescale 1ns/1ps
`include "omlc_defs.svh"
// ----
// Bench
// ----
module tb_output_mute_level_control;
	logic        pclk, presetn, psel, penable, pwrite, si, pready, pslverr, er; // Bus and pin
	logic [7:0]  paddr, dif, lv, cfg;       // Address, diff, model levels and config
	logic [31:0] pwdata, prdata, rd;        // Data
	logic [3:0]  mut, pl, nl;               // Driver outputs
	int          num_errors, n_checks;      // Counters
	omlc_output_mute_level_control dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .source_invalid(si), .driver_muted(mut),
		.diff_action(dif), .cmos_force_p_low(pl), .cmos_force_n_low(nl));
	initial
	begin
		pclk = 0;
		forever #2 pclk = ~pclk;
	end
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e)
		begin
			num_errors++;
			$display("mismatch t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	// One APB transfer; idle edge after so psel never toggles twice
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge pclk);
	endtask
	// Model: enabled drivers take their coded state while source is bad
	task automatic muted_check(input logic on);
		logic [3:0] em, ep, en;
		logic [7:0] ed;
		int c;
		{em, ep, en, ed} = '0;
		for (int i = 0; i < 4; i++)
			if (on && cfg[i])
			begin
				c = (lv >> (2 * i)) & 3;
				em[i] = 1;
				if (cfg[4 + i]) {ep[i], en[i]} = c[1:0];
				else ed[2 * i +: 2] = c[1:0];
			end
		chk({28'h0, mut}, {28'h0, em});
		chk({24'h0, dif}, {24'h0, ed});
		chk({24'h0, pl, nl}, {24'h0, ep, en});
	endtask
	task automatic close_out;
		$display("errors %0d checks %0d", num_errors, n_checks);
		if (num_errors == 0 && n_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	initial
	begin
		#20000;
		num_errors++;
		close_out;
	end
	initial
	begin
		{presetn, psel, penable, pwrite, si, paddr, pwdata} = '0;
		void'($urandom(49));
		repeat (3) @(posedge pclk);
		presetn <= 1;
		xfer(0, `OMLC_LEVELS_ADDR, 0);
		chk(rd, {24'h0, `OMLC_LEVELS_RESET});
		chk({31'h0, er}, 32'h0);
		xfer(0, `OMLC_SILENCE_ADDR, 0);
		chk(rd, {24'h0, `OMLC_MODE_RESET, `OMLC_SILENCE_RESET});
		xfer(0, 8'h60, 0);
		chk({er, rd[30:0]}, 32'h8000_0000);
		for (int k = 0; k < 8; k++)
		begin
			// Fixed patterns first: every code in both modes, then all fields at 3
			lv = k < 2 ? 8'h1B : k == 2 ? 8'hFF : 8'($urandom);
			cfg = k == 0 ? 8'h0F : k == 1 ? 8'hFF : 8'($urandom);
			xfer(1, `OMLC_LEVELS_ADDR, {24'($urandom), lv});
			xfer(1, `OMLC_SILENCE_ADDR, {24'h0, cfg});
			xfer(0, `OMLC_LEVELS_ADDR, 0);
			chk(rd, {24'h0, lv});
			si <= 1;
			repeat (8) @(posedge pclk);
			muted_check(1);
			xfer(0, `OMLC_STATUS_ADDR, 0);
			chk(rd, {27'h0, 1'b1, cfg[3:0]});
			si <= 0;
			repeat (8) @(posedge pclk);
			muted_check(0);
			xfer(0, `OMLC_STATUS_ADDR, 0);
			chk(rd, 32'h0);
		end
		// Stray writes: unmapped one refused, status one ignored quietly
		xfer(1, 8'h60, 32'hFFFF_FFFF);
		chk({31'h0, er}, 32'h1);
		xfer(1, `OMLC_STATUS_ADDR, 32'hFFFF_FFFF);
		chk({31'h0, er}, 32'h0);
		xfer(0, `OMLC_LEVELS_ADDR, 0);
		chk(rd, {24'h0, lv});
		xfer(0, `OMLC_SILENCE_ADDR, 0);
		chk(rd, {24'h0, cfg});
		// Mid-run reset must bring back the defaults
		presetn <= 0;
		repeat (3) @(posedge pclk);
		presetn <= 1;
		xfer(0, `OMLC_LEVELS_ADDR, 0);
		chk(rd, {24'h0, `OMLC_LEVELS_RESET});
		xfer(0, `OMLC_SILENCE_ADDR, 0);
		chk(rd, {24'h0, `OMLC_MODE_RESET, `OMLC_SILENCE_RESET});
		close_out;
	end
endmodule
